// [src/cil_defs.svh]
`ifndef CIL_DEFS_SVH
`define CIL_DEFS_SVH

// Bus widths
`define CIL_AW 12
`define CIL_DW 32
`define CIL_TMR_W 32
`define CIL_NSTK 3

// Register byte addresses
`define CIL_ADDR_LATCH 12'h000
`define CIL_ADDR_STATUS 12'h004
`define CIL_ADDR_CLEAR 12'h008
`define CIL_ADDR_ENABLE 12'h00C

// Latch register bit positions
`define CIL_BIT_STACK 7
`define CIL_BIT_BADADDR 8
`define CIL_BIT_CH3 9
`define CIL_BIT_CH4 10
`define CIL_BIT_TMR_HI 11
`define CIL_BIT_TMR_LO 20

// Implemented latch bits and reset values
`define CIL_LATCH_MASK 32'h0010_0F80
`define CIL_LATCH_RST 32'h0000_0000
`define CIL_EV_RST 6'h00

// Event layout of status, clear and enable registers
`define CIL_EV_NUM 6
`define CIL_EV_TMR_HI 0
`define CIL_EV_TMR_LO 1
`define CIL_EV_CH4 2
`define CIL_EV_CH3 3
`define CIL_EV_BAD 4
`define CIL_EV_STK 5

// Bus responses and timer values
`define CIL_RESP_OKAY 2'h0
`define CIL_RESP_SLVERR 2'h2
`define CIL_TMR_ONE 32'h0000_0001
`define CIL_TMR_ZERO 32'h0000_0000

`endif

// [src/cil_pkg.sv]
`include "cil_defs.svh"

package cil_pkg;
  // Write channel state, Gray along idle, apply, respond
  typedef enum logic [1:0] {WR_IDLE = 2'h0, WR_APPLY = 2'h1, WR_RESP = 2'h3} cil_wr_state_type;
  // Read channel state
  typedef enum logic {RD_IDLE = 1'h0, RD_RESP = 1'h1} cil_rd_state_type;
  // Access size of a data move
  typedef enum logic [1:0] {SZ_BYTE, SZ_SHORT, SZ_NORMAL, SZ_LONG} cil_size_type;
  // Address space of an address or index register
  typedef enum logic [1:0] {SP_BYTE, SP_SHORT, SP_NORMAL, SP_LONG} cil_space_type;
  // Option carried by a modify instruction
  typedef enum logic [1:0] {MOD_PLAIN, MOD_SHORT_WORD, MOD_NORMAL_WORD} cil_modopt_type;

  // Event decoder state
  typedef struct packed {
    logic [`CIL_TMR_W-1:0] timer_count_value;
    logic [`CIL_EV_NUM-1:0] ev;
  } cil_dec_state_type;

  // Interrupt status block state
  typedef struct packed {
    logic [`CIL_EV_NUM-1:0] sts;
    logic [`CIL_EV_NUM-1:0] en;
    logic irq;
  } cil_irq_state_type;

  // Top level state: bus slave and latch register
  typedef struct packed {
    cil_wr_state_type wst;
    logic aw_got;
    logic w_got;
    logic [`CIL_AW-1:0] waddr;
    logic [`CIL_DW-1:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    cil_rd_state_type rst;
    logic [`CIL_DW-1:0] rdata;
    logic [1:0] rresp;
    logic [`CIL_DW-1:0] latch;
  } cil_top_state_type;
endpackage

// [src/cil_if.sv]
`timescale 1ns/1ps
`include "cil_defs.svh"

// Event pulses from the decoder
interface cil_evt_if;
  logic [`CIL_EV_NUM-1:0] ev;
  modport source(output ev);
  modport sink(input ev);
endinterface

// Status, clear and enable access for the interrupt block
interface cil_irq_if;
  logic clr_wr;
  logic en_wr;
  logic [7:0] wbyte;
  logic [`CIL_EV_NUM-1:0] sts;
  logic [`CIL_EV_NUM-1:0] en;
  logic irq;
  modport regs(output clr_wr, output en_wr, output wbyte, input sts, input en, input irq);
  modport ctrl(input clr_wr, input en_wr, input wbyte, output sts, output en, output irq);
endinterface

// [src/cil_event_decode.sv]
`timescale 1ns/1ps
`include "cil_defs.svh"

module cil_event_decode (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // Core timer
  input wire logic [`CIL_TMR_W-1:0] timer_count_value_in,
  // Filter channels
  input wire logic filter_ch3_done_in,
  input wire logic filter_ch4_done_in,
  // Address generators
  input wire logic access_valid_in,
  input wire cil_pkg::cil_size_type access_size_in,
  input wire cil_pkg::cil_space_type access_space_in,
  input wire logic modify_valid_in,
  input wire cil_pkg::cil_modopt_type modify_option_in,
  input wire cil_pkg::cil_space_type modify_space_in,
  // Sequencer stacks
  input wire logic [`CIL_NSTK-1:0] stack_overflow_in,
  input wire logic [`CIL_NSTK-1:0] stack_full_in,
  // Event pulses out
  cil_evt_if.source evt
);
  cil_pkg::cil_dec_state_type s_q; // Registered state
  cil_pkg::cil_dec_state_type s_d; // Next state
  logic expiry; // Timer stepped from one to zero

  // Decode every source into one registered pulse per event
  always_comb begin
    s_d = s_q;
    s_d.timer_count_value = timer_count_value_in;
    expiry = (s_q.timer_count_value == `CIL_TMR_ONE) && (timer_count_value_in == `CIL_TMR_ZERO);
    s_d.ev[`CIL_EV_TMR_HI] = expiry;
    s_d.ev[`CIL_EV_TMR_LO] = expiry;
    s_d.ev[`CIL_EV_CH4] = filter_ch4_done_in;
    s_d.ev[`CIL_EV_CH3] = filter_ch3_done_in;
    s_d.ev[`CIL_EV_BAD] =
      (access_valid_in && (access_size_in == cil_pkg::SZ_BYTE ||
        access_size_in == cil_pkg::SZ_SHORT) && access_space_in != cil_pkg::SP_BYTE) ||
      (modify_valid_in && modify_option_in == cil_pkg::MOD_SHORT_WORD &&
        modify_space_in != cil_pkg::SP_BYTE) ||
      (modify_valid_in && modify_option_in == cil_pkg::MOD_NORMAL_WORD &&
        (modify_space_in == cil_pkg::SP_LONG || modify_space_in == cil_pkg::SP_SHORT));
    s_d.ev[`CIL_EV_STK] = |(stack_overflow_in | stack_full_in);
  end

  // State register
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign evt.ev = s_q.ev;
endmodule

// [src/cil_irq_ctrl.sv]
`timescale 1ns/1ps
`include "cil_defs.svh"

module cil_irq_ctrl (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // Events in
  cil_evt_if.sink evt,
  // Register access
  cil_irq_if.ctrl irq_bus
);
  cil_pkg::cil_irq_state_type s_q; // Registered state
  cil_pkg::cil_irq_state_type s_d; // Next state

  // Sticky status, write-one-to-clear, set beats clear
  always_comb begin
    s_d = s_q;
    if (irq_bus.clr_wr) begin
      s_d.sts = s_q.sts & ~irq_bus.wbyte[`CIL_EV_NUM-1:0];
    end
    s_d.sts = s_d.sts | evt.ev;
    if (irq_bus.en_wr) begin
      s_d.en = irq_bus.wbyte[`CIL_EV_NUM-1:0];
    end
    s_d.irq = |(s_d.sts & s_d.en);
  end

  // State register
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_q <= '{sts: `CIL_EV_RST, en: `CIL_EV_RST, irq: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign irq_bus.sts = s_q.sts;
  assign irq_bus.en = s_q.en;
  assign irq_bus.irq = s_q.irq;
endmodule

// [src/cil_top.sv]
`timescale 1ns/1ps
`include "cil_defs.svh"

//Contract
// - High-priority timer latch sits at bit 11
// - Timer count reaching zero sets high latch
// - Same expiry also sets low-priority timer latch
// - Fourth filter channel done sets bit 10
// - Third filter channel done sets bit 9
// - Byte/short access outside byte space sets bit 8
// - Short-word modify, non-byte index sets bit 8
// - Normal-word modify, long/short index sets bit 8
// - Any stack overflow or full sets bit 7
module cil_top (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // AXI4-Lite write address
  input wire logic [`CIL_AW-1:0] axi_awaddr_in,
  input wire logic [2:0] axi_awprot_in,
  input wire logic axi_awvalid_in,
  output logic axi_awready_out,
  // AXI4-Lite write data
  input wire logic [`CIL_DW-1:0] axi_wdata_in,
  input wire logic [3:0] axi_wstrb_in,
  input wire logic axi_wvalid_in,
  output logic axi_wready_out,
  // AXI4-Lite write response
  output logic [1:0] axi_bresp_out,
  output logic axi_bvalid_out,
  input wire logic axi_bready_in,
  // AXI4-Lite read address
  input wire logic [`CIL_AW-1:0] axi_araddr_in,
  input wire logic [2:0] axi_arprot_in,
  input wire logic axi_arvalid_in,
  output logic axi_arready_out,
  // AXI4-Lite read data
  output logic [`CIL_DW-1:0] axi_rdata_out,
  output logic [1:0] axi_rresp_out,
  output logic axi_rvalid_out,
  input wire logic axi_rready_in,
  // Core timer
  input wire logic [`CIL_TMR_W-1:0] timer_count_value_in,
  // Filter channels
  input wire logic filter_ch3_done_in,
  input wire logic filter_ch4_done_in,
  // Address generators
  input wire logic access_valid_in,
  input wire cil_pkg::cil_size_type access_size_in,
  input wire cil_pkg::cil_space_type access_space_in,
  input wire logic modify_valid_in,
  input wire cil_pkg::cil_modopt_type modify_option_in,
  input wire cil_pkg::cil_space_type modify_space_in,
  // Sequencer stacks
  input wire logic [`CIL_NSTK-1:0] stack_overflow_in,
  input wire logic [`CIL_NSTK-1:0] stack_full_in,
  // Per-bit latch outputs
  output logic timer_expiry_high_prio_latch_out,
  output logic timer_expiry_low_prio_latch_out,
  output logic filter_ch4_done_latch_out,
  output logic filter_ch3_done_latch_out,
  output logic bad_address_latch_out,
  output logic stack_overflow_latch_out,
  // Interrupt
  output logic irq_out
);

  // Registered state of the slave and latch register
  cil_pkg::cil_top_state_type s_q;
  // Next value of that state
  cil_pkg::cil_top_state_type s_d;

  // Event pulses from the decoder
  cil_evt_if evt();
  // Status and enable access
  cil_irq_if irq_bus();

  // Byte lane mask built from the held strobes
  logic [`CIL_DW-1:0] wmask;
  // Write address handshake this cycle
  logic aw_hs;
  // Write data handshake this cycle
  logic w_hs;
  // Held write is being applied this cycle
  logic wr_apply;
  // Held write address decodes
  logic wr_latch;
  logic wr_status;
  logic wr_clear;
  logic wr_enable;
  // Held write address is mapped
  logic wr_mapped;
  // Event set vector aligned to the latch register
  logic [`CIL_DW-1:0] ev_set;
  // Read data chosen for the read address
  logic [`CIL_DW-1:0] rd_mux;
  // Read address is mapped
  logic rd_mapped;

  // Source decoding lives in its own block
  cil_event_decode u_dec (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .timer_count_value_in(timer_count_value_in),
    .filter_ch3_done_in(filter_ch3_done_in),
    .filter_ch4_done_in(filter_ch4_done_in),
    .access_valid_in(access_valid_in),
    .access_size_in(access_size_in),
    .access_space_in(access_space_in),
    .modify_valid_in(modify_valid_in),
    .modify_option_in(modify_option_in),
    .modify_space_in(modify_space_in),
    .stack_overflow_in(stack_overflow_in),
    .stack_full_in(stack_full_in),
    .evt(evt.source)
  );

  // Sticky status, enable and interrupt output
  cil_irq_ctrl u_irq (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .evt(evt.sink),
    .irq_bus(irq_bus.ctrl)
  );

  // Expand each write strobe to its byte lane
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign wmask[8*gi +: 8] = {8{s_q.wstrb[gi]}};
    end
  endgenerate

  // Map decoder events onto their latch positions
  always_comb begin
    ev_set = '0;
    ev_set[`CIL_BIT_TMR_HI] = evt.ev[`CIL_EV_TMR_HI];
    ev_set[`CIL_BIT_TMR_LO] = evt.ev[`CIL_EV_TMR_LO];
    ev_set[`CIL_BIT_CH4] = evt.ev[`CIL_EV_CH4];
    ev_set[`CIL_BIT_CH3] = evt.ev[`CIL_EV_CH3];
    ev_set[`CIL_BIT_BADADDR] = evt.ev[`CIL_EV_BAD];
    ev_set[`CIL_BIT_STACK] = evt.ev[`CIL_EV_STK];
  end

  // Handshakes and decode of the held write
  always_comb begin
    aw_hs = axi_awvalid_in && axi_awready_out;
    w_hs = axi_wvalid_in && axi_wready_out;
    wr_apply = (s_q.wst == cil_pkg::WR_APPLY);
    wr_latch = (s_q.waddr == `CIL_ADDR_LATCH);
    wr_status = (s_q.waddr == `CIL_ADDR_STATUS);
    wr_clear = (s_q.waddr == `CIL_ADDR_CLEAR);
    wr_enable = (s_q.waddr == `CIL_ADDR_ENABLE);
    wr_mapped = wr_latch || wr_status || wr_clear || wr_enable;
  end

  // Read data multiplexer; clear register reads zero
  always_comb begin
    rd_mux = '0;
    rd_mapped = 1'b1;
    case (axi_araddr_in)
      `CIL_ADDR_LATCH: begin
        rd_mux = s_q.latch;
      end
      `CIL_ADDR_STATUS: begin
        rd_mux[`CIL_EV_NUM-1:0] = irq_bus.sts;
      end
      `CIL_ADDR_CLEAR: begin
        rd_mux = '0;
      end
      `CIL_ADDR_ENABLE: begin
        rd_mux[`CIL_EV_NUM-1:0] = irq_bus.en;
      end
      default: begin
        rd_mapped = 1'b0;
      end
    endcase
  end

  // Only the low byte reaches the status block when its lane is on
  assign irq_bus.wbyte = s_q.wdata[7:0];
  // Clear register: write ones to drop status bits
  assign irq_bus.clr_wr = wr_apply && wr_clear && s_q.wstrb[0];
  // Enable register: replaced whole from the low byte
  assign irq_bus.en_wr = wr_apply && wr_enable && s_q.wstrb[0];

  // Ready while idle and that half is not yet held
  assign axi_awready_out = (s_q.wst == cil_pkg::WR_IDLE) && !s_q.aw_got;
  assign axi_wready_out = (s_q.wst == cil_pkg::WR_IDLE) && !s_q.w_got;
  // Response valid comes straight from the state
  assign axi_bvalid_out = (s_q.wst == cil_pkg::WR_RESP);
  assign axi_bresp_out = s_q.bresp;
  // Read address taken only while no read data waits
  assign axi_arready_out = (s_q.rst == cil_pkg::RD_IDLE);
  assign axi_rvalid_out = (s_q.rst == cil_pkg::RD_RESP);
  assign axi_rdata_out = s_q.rdata;
  assign axi_rresp_out = s_q.rresp;

  // Next state of slave and latch register
  always_comb begin
    s_d = s_q;

    // Catch address and data in either order
    if (aw_hs) begin
      s_d.aw_got = 1'b1;
      s_d.waddr = axi_awaddr_in;
    end
    if (w_hs) begin
      s_d.w_got = 1'b1;
      s_d.wdata = axi_wdata_in;
      s_d.wstrb = axi_wstrb_in;
    end

    // Write channel sequence
    case (s_q.wst)
      cil_pkg::WR_IDLE: begin
        // Both halves held: apply in the next cycle
        if (s_q.aw_got && s_q.w_got) begin
          s_d.wst = cil_pkg::WR_APPLY;
        end
      end
      cil_pkg::WR_APPLY: begin
        // Effect lands this cycle, answer follows
        s_d.aw_got = 1'b0;
        s_d.w_got = 1'b0;
        s_d.bresp = wr_mapped ? `CIL_RESP_OKAY : `CIL_RESP_SLVERR;
        s_d.wst = cil_pkg::WR_RESP;
      end
      cil_pkg::WR_RESP: begin
        // Hold the response until the master takes it
        if (axi_bready_in) begin
          s_d.wst = cil_pkg::WR_IDLE;
        end
      end
      default: begin
        s_d.wst = cil_pkg::WR_IDLE;
      end
    endcase

    // Read channel sequence
    case (s_q.rst)
      cil_pkg::RD_IDLE: begin
        // Capture data and answer one cycle later
        if (axi_arvalid_in) begin
          s_d.rdata = rd_mux;
          s_d.rresp = rd_mapped ? `CIL_RESP_OKAY : `CIL_RESP_SLVERR;
          s_d.rst = cil_pkg::RD_RESP;
        end
      end
      cil_pkg::RD_RESP: begin
        // Hold data until the master takes it
        if (axi_rready_in) begin
          s_d.rst = cil_pkg::RD_IDLE;
        end
      end
      default: begin
        s_d.rst = cil_pkg::RD_IDLE;
      end
    endcase

    // Software write sets or clears the covered bits by lane
    if (wr_apply && wr_latch) begin
      s_d.latch = (s_q.latch & ~(wmask & `CIL_LATCH_MASK)) |
                  (s_q.wdata & wmask & `CIL_LATCH_MASK);
    end
    // Bits hold otherwise; a new event wins over a clearing write
    s_d.latch = (s_d.latch | ev_set) & `CIL_LATCH_MASK;
  end

  // State register
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_q <= '{wst: cil_pkg::WR_IDLE, aw_got: 1'b0, w_got: 1'b0,
               waddr: '0, wdata: '0, wstrb: '0, bresp: `CIL_RESP_OKAY,
               rst: cil_pkg::RD_IDLE, rdata: '0, rresp: `CIL_RESP_OKAY,
               latch: `CIL_LATCH_RST};
    end else begin
      s_q <= s_d;
    end
  end

  // Per-bit latch outputs to the rest of the interrupt unit
  assign timer_expiry_high_prio_latch_out = s_q.latch[`CIL_BIT_TMR_HI];
  assign timer_expiry_low_prio_latch_out = s_q.latch[`CIL_BIT_TMR_LO];
  assign filter_ch4_done_latch_out = s_q.latch[`CIL_BIT_CH4];
  assign filter_ch3_done_latch_out = s_q.latch[`CIL_BIT_CH3];
  assign bad_address_latch_out = s_q.latch[`CIL_BIT_BADADDR];
  assign stack_overflow_latch_out = s_q.latch[`CIL_BIT_STACK];

  // Interrupt level comes from a flip-flop in the status block
  assign irq_out = irq_bus.irq;

endmodule

// [sim/cil_timer_model.sv]
`timescale 1ns/1ps

// Core timer stand-in: loads a count, then steps down once a cycle and parks at zero
module cil_timer_model (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // Load control from the bench
  input wire logic load_in,
  input wire logic [31:0] load_val_in,
  // Count seen by the latch block
  output logic [31:0] count_out
);
  // Count register; parking at zero avoids a second expiry without a reload
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count_out <= 32'h0000_0000;
    end else if (load_in) begin
      count_out <= load_val_in;
    end else if (count_out != 32'h0000_0000) begin
      count_out <= count_out - 32'h0000_0001;
    end
  end
endmodule

// [sim/cil_top_chk.sv]
`timescale 1ns/1ps
`include "cil_defs.svh"

module cil_top_chk (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // Event inputs
  input wire logic [`CIL_TMR_W-1:0] timer_count_value_in,
  input wire logic filter_ch3_done_in,
  input wire logic filter_ch4_done_in,
  input wire logic access_valid_in,
  input wire cil_pkg::cil_size_type access_size_in,
  input wire cil_pkg::cil_space_type access_space_in,
  input wire logic modify_valid_in,
  input wire cil_pkg::cil_modopt_type modify_option_in,
  input wire cil_pkg::cil_space_type modify_space_in,
  input wire logic [`CIL_NSTK-1:0] stack_overflow_in,
  input wire logic [`CIL_NSTK-1:0] stack_full_in,
  // Observed outputs
  input wire logic axi_bvalid_out,
  input wire logic timer_expiry_high_prio_latch_out,
  input wire logic timer_expiry_low_prio_latch_out,
  input wire logic filter_ch4_done_latch_out,
  input wire logic filter_ch3_done_latch_out,
  input wire logic bad_address_latch_out,
  input wire logic stack_overflow_latch_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  // Timer count stepping from one down to zero
  sequence expiry_s;
    (timer_count_value_in == `CIL_TMR_ONE) ##1 (timer_count_value_in == `CIL_TMR_ZERO);
  endsequence
  chk_timer_high_set: assert property (expiry_s |=> ##1 timer_expiry_high_prio_latch_out)
    else $error("high priority timer latch not set");
  chk_timer_low_set: assert property (expiry_s |=> ##1 timer_expiry_low_prio_latch_out)
    else $error("low priority timer latch not set");
  chk_ch4_done_set: assert property (filter_ch4_done_in |=> ##1 filter_ch4_done_latch_out)
    else $error("channel four latch not set");
  chk_ch3_done_set: assert property (filter_ch3_done_in |=> ##1 filter_ch3_done_latch_out)
    else $error("channel three latch not set");
  chk_bad_access_set: assert property (access_valid_in && access_size_in < cil_pkg::SZ_NORMAL
    && access_space_in != cil_pkg::SP_BYTE |=> ##1 bad_address_latch_out)
    else $error("bad access not latched");
  chk_bad_sw_modify: assert property (modify_valid_in && modify_space_in != cil_pkg::SP_BYTE
    && modify_option_in == cil_pkg::MOD_SHORT_WORD |=> ##1 bad_address_latch_out)
    else $error("short word modify not latched");
  chk_bad_nw_modify: assert property (modify_valid_in
    && modify_option_in == cil_pkg::MOD_NORMAL_WORD
    && modify_space_in inside {cil_pkg::SP_SHORT, cil_pkg::SP_LONG}
    |=> ##1 bad_address_latch_out)
    else $error("normal word modify not latched");
  chk_stack_event_set: assert property (|(stack_overflow_in | stack_full_in)
    |=> ##1 stack_overflow_latch_out)
    else $error("stack latch not set");
  chk_latch_held: assert property ($fell(filter_ch3_done_latch_out) |-> $rose(axi_bvalid_out))
    else $error("latch dropped without a write");
  // Main scenarios reached
  cover property (expiry_s);
  cover property ($fell(filter_ch3_done_latch_out));
  cover property ($rose(bad_address_latch_out));
endmodule

bind cil_top cil_top_chk chk_i (.*);

// [sim/cil_top_tb_top.sv]
`timescale 1ns/1ps
`include "cil_defs.svh"

// Compare and count one value
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end

module cil_top_tb_top;
  // Event row: {ch4,ch3}, access valid/size/space, modify valid/option/space, ovf, full, expected
  typedef struct packed {
    logic [1:0] fl;
    logic av;
    logic [1:0] sz, sp;
    logic mv;
    logic [1:0] op, ms;
    logic [2:0] ov, fu;
    logic [5:0] ex;
  } cil_row_type;
  // Clock, reset and bus
  logic sys_clk_in = 1'h0;
  logic rst_b_in = 1'h0;
  logic [11:0] axi_awaddr_in = 12'h000, axi_araddr_in = 12'h000;
  logic [2:0] axi_awprot_in = 3'h0, axi_arprot_in = 3'h0;
  logic axi_awvalid_in = 1'h0, axi_wvalid_in = 1'h0, axi_arvalid_in = 1'h0;
  logic axi_bready_in = 1'h1, axi_rready_in = 1'h1;
  logic [31:0] axi_wdata_in = 32'h0000_0000;
  logic [3:0] axi_wstrb_in = 4'hf;
  logic axi_awready_out, axi_wready_out, axi_bvalid_out, axi_arready_out, axi_rvalid_out;
  logic [1:0] axi_bresp_out, axi_rresp_out, wr_resp, rd_resp;
  logic [31:0] axi_rdata_out, rd_data;
  // Event sources
  logic [31:0] timer_count_value_in;
  logic filter_ch3_done_in = 1'h0, filter_ch4_done_in = 1'h0;
  logic access_valid_in = 1'h0, modify_valid_in = 1'h0;
  cil_pkg::cil_size_type access_size_in = cil_pkg::SZ_BYTE;
  cil_pkg::cil_space_type access_space_in = cil_pkg::SP_BYTE, modify_space_in = cil_pkg::SP_BYTE;
  cil_pkg::cil_modopt_type modify_option_in = cil_pkg::MOD_PLAIN;
  logic [2:0] stack_overflow_in = 3'h0, stack_full_in = 3'h0;
  // Latch outputs and interrupt
  logic timer_expiry_high_prio_latch_out, timer_expiry_low_prio_latch_out;
  logic filter_ch4_done_latch_out, filter_ch3_done_latch_out;
  logic bad_address_latch_out, stack_overflow_latch_out, irq_out;
  // Timer model load, bookkeeping, event table
  logic tmr_load = 1'h0;
  logic [31:0] tmr_val = 32'h0000_0000;
  int fail_count = 0, comparisons = 0, cycles = 0;
  cil_row_type rows [12];
  logic [5:0] lat;
  assign lat = {timer_expiry_high_prio_latch_out, timer_expiry_low_prio_latch_out,
    filter_ch4_done_latch_out, filter_ch3_done_latch_out, bad_address_latch_out,
    stack_overflow_latch_out};

  cil_top dut (.*);
  cil_timer_model tmr (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .load_in(tmr_load),
    .load_val_in(tmr_val), .count_out(timer_count_value_in));

  // Clock and hang guard
  always #2 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      print_verdict();
    end
  end

  // Counts, verdict and end of run
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Write one word; each half drops once taken, ends at the response edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    axi_awaddr_in <= a;
    axi_wdata_in <= d;
    axi_awvalid_in <= 1'h1;
    axi_wvalid_in <= 1'h1;
    do begin
      @(negedge sys_clk_in);
      ta = axi_awvalid_in && axi_awready_out;
      tw = axi_wvalid_in && axi_wready_out;
      tb = axi_bvalid_out;
      wr_resp = axi_bresp_out;
      @(posedge sys_clk_in);
      if (ta) axi_awvalid_in <= 1'h0;
      if (tw) axi_wvalid_in <= 1'h0;
    end while (!tb);
  endtask

  // Read one word into rd_data and rd_resp
  task automatic rd(input logic [11:0] a);
    logic t;
    axi_araddr_in <= a;
    axi_arvalid_in <= 1'h1;
    do begin
      @(negedge sys_clk_in);
      t = axi_arready_out;
      @(posedge sys_clk_in);
    end while (!t);
    axi_arvalid_in <= 1'h0;
    do begin
      @(negedge sys_clk_in);
      t = axi_rvalid_out;
      rd_data = axi_rdata_out;
      rd_resp = axi_rresp_out;
      @(posedge sys_clk_in);
    end while (!t);
  endtask

  // Let the interrupt flop follow a register change, then look at it
  task automatic chk_irq(input logic e);
    repeat (2) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    `CHK(irq_out, e)
    @(posedge sys_clk_in);
  endtask

  // Main sequence
  initial begin
    rows[0] = '{2'h2, 1'h0, 2'h0, 2'h0, 1'h0, 2'h0, 2'h0, 3'h0, 3'h0, 6'h08};
    rows[1] = '{2'h1, 1'h0, 2'h0, 2'h0, 1'h0, 2'h0, 2'h0, 3'h0, 3'h0, 6'h04};
    rows[2] = '{2'h0, 1'h1, 2'h0, 2'h1, 1'h0, 2'h0, 2'h0, 3'h0, 3'h0, 6'h02};
    rows[3] = '{2'h0, 1'h1, 2'h1, 2'h3, 1'h0, 2'h0, 2'h0, 3'h0, 3'h0, 6'h02};
    rows[4] = '{2'h0, 1'h1, 2'h0, 2'h0, 1'h0, 2'h0, 2'h0, 3'h0, 3'h0, 6'h00};
    rows[5] = '{2'h0, 1'h1, 2'h3, 2'h2, 1'h0, 2'h0, 2'h0, 3'h0, 3'h0, 6'h00};
    rows[6] = '{2'h0, 1'h0, 2'h0, 2'h0, 1'h1, 2'h1, 2'h2, 3'h0, 3'h0, 6'h02};
    rows[7] = '{2'h0, 1'h0, 2'h0, 2'h0, 1'h1, 2'h1, 2'h0, 3'h0, 3'h0, 6'h00};
    rows[8] = '{2'h0, 1'h0, 2'h0, 2'h0, 1'h1, 2'h2, 2'h1, 3'h0, 3'h0, 6'h02};
    rows[9] = '{2'h0, 1'h0, 2'h0, 2'h0, 1'h1, 2'h2, 2'h2, 3'h0, 3'h0, 6'h00};
    rows[10] = '{2'h0, 1'h0, 2'h0, 2'h0, 1'h0, 2'h0, 2'h0, 3'h4, 3'h0, 6'h01};
    rows[11] = '{2'h0, 1'h0, 2'h0, 2'h0, 1'h0, 2'h0, 2'h0, 3'h0, 3'h1, 6'h01};
    repeat (5) @(posedge sys_clk_in);
    rst_b_in <= 1'h1;
    @(posedge sys_clk_in);
    rd(`CIL_ADDR_LATCH);
    `CHK(rd_data, `CIL_LATCH_RST)
    rd(`CIL_ADDR_ENABLE);
    `CHK(rd_data, 32'h0000_0000)
    $display("test reset done");
    // One source per row, checked at the latch outputs, then cleared by software
    for (int i = 0; i < 12; i++) begin
      {filter_ch4_done_in, filter_ch3_done_in} <= rows[i].fl;
      access_valid_in <= rows[i].av;
      access_size_in <= cil_pkg::cil_size_type'(rows[i].sz);
      access_space_in <= cil_pkg::cil_space_type'(rows[i].sp);
      modify_valid_in <= rows[i].mv;
      modify_option_in <= cil_pkg::cil_modopt_type'(rows[i].op);
      modify_space_in <= cil_pkg::cil_space_type'(rows[i].ms);
      stack_overflow_in <= rows[i].ov;
      stack_full_in <= rows[i].fu;
      @(posedge sys_clk_in);
      {filter_ch4_done_in, filter_ch3_done_in, access_valid_in, modify_valid_in} <= 4'h0;
      {stack_overflow_in, stack_full_in} <= 6'h00;
      @(negedge sys_clk_in);
      @(negedge sys_clk_in);
      `CHK(lat, rows[i].ex)
      @(posedge sys_clk_in);
      wr(`CIL_ADDR_LATCH, 32'h0000_0000);
      wr(`CIL_ADDR_CLEAR, 32'h0000_003f);
    end
    $display("test event table done");
    // Timer expiry with only the high priority interrupt unmasked
    wr(`CIL_ADDR_ENABLE, 32'h0000_0001);
    tmr_val <= 32'h0000_0003;
    tmr_load <= 1'h1;
    @(posedge sys_clk_in);
    tmr_load <= 1'h0;
    repeat (6) @(posedge sys_clk_in);
    rd(`CIL_ADDR_LATCH);
    `CHK(rd_data, 32'h0010_0800)
    rd(`CIL_ADDR_STATUS);
    `CHK(rd_data, 32'h0000_0003)
    chk_irq(1'h1);
    wr(`CIL_ADDR_ENABLE, 32'h0000_0000);
    chk_irq(1'h0);
    wr(`CIL_ADDR_ENABLE, 32'h0000_0001);
    chk_irq(1'h1);
    wr(`CIL_ADDR_CLEAR, 32'h0000_0001);
    chk_irq(1'h0);
    rd(`CIL_ADDR_STATUS);
    `CHK(rd_data, 32'h0000_0002)
    rd(`CIL_ADDR_CLEAR);
    `CHK(rd_data, 32'h0000_0000)
    $display("test timer and interrupt done");
    // Direct software load of the latch register, and an event beating a clearing write
    wr(`CIL_ADDR_LATCH, 32'hffff_ffff);
    rd(`CIL_ADDR_LATCH);
    `CHK(rd_data, `CIL_LATCH_MASK)
    // One pulse whose decoded event lands on the very edge that applies the clearing write
    fork
      wr(`CIL_ADDR_LATCH, 32'h0000_0000);
      begin
        @(posedge sys_clk_in);
        filter_ch3_done_in <= 1'h1;
        @(posedge sys_clk_in);
        filter_ch3_done_in <= 1'h0;
      end
    join
    rd(`CIL_ADDR_LATCH);
    `CHK(rd_data, 32'h0000_0200)
    $display("test latch writes done");
    // Unmapped address on both directions
    wr(12'h010, 32'hffff_ffff);
    `CHK(wr_resp, `CIL_RESP_SLVERR)
    rd(12'h010);
    `CHK({rd_resp, rd_data}, {`CIL_RESP_SLVERR, 32'h0000_0000})
    $display("test unmapped done");
    print_verdict();
  end
endmodule
